// ===== spc_map.svh
// Register map, field positions, reset values and counts of the serial port controller
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPC_OFF_DATA 3'h0
`define SPC_OFF_CTL 3'h1
`define SPC_OFF_CFG 3'h2
`define SPC_OFF_DIV 3'h3
`define SPC_OFF_EVT 3'h4
`define SPC_OFF_MASK 3'h5

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define SPC_CN_EN 0
`define SPC_CN_MS 1
`define SPC_CN_FDE 2
`define SPC_CN_FLAG_LSB 3
`define SPC_CN_FLAG_MSB 6
`define SPC_CN_BUSY 7

// ----------------------------------------
// Format configuration fields
// ----------------------------------------
`define SPC_CF_POL 0
`define SPC_CF_PHA 1
`define SPC_CF_CHR 2
`define SPC_CF_IE 7
`define SPC_CF_MASK 8'h87

// ----------------------------------------
// Event bits (same order as the flags)
// ----------------------------------------
`define SPC_EV_FAULT 0
`define SPC_EV_WRITE_COLLISION_FLAG 1
`define SPC_EV_OVR 2
`define SPC_EV_DONE 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define SPC_RST_WORD 16'h0000
`define SPC_RST_BYTE 8'h00
`define SPC_RST_CTL 7'h00
// Synchroniser reset levels: clock, data in, data out low, select high (idle)
`define SPC_SYNC_RST 4'h1
`define SPC_RST_EVT 4'h0
`define SPC_RST_MASK 4'hF
`define SPC_RST_EDGE 6'h00
`define SPC_CHAR_SHORT 6'h08
`define SPC_CHAR_LONG 6'h10
`define SPC_READ_ZERO 16'h0000

`endif

// ===== spc_pkg.sv
// Types shared by the serial port controller files
package spc_pkg;

    // Pins arriving from the link
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic miso;
        logic ssel_n;
    } spc_pin_in_t;

    // Pins driven toward the link, each with its enable
    typedef struct packed {
        logic sclk_out;
        logic sclk_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
    } spc_pin_out_t;

    // Shift engine state
    typedef enum logic {
        SPC_IDLE,
        SPC_RUN
    } spc_state_t;

endpackage

// ===== spc_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps

// Reset level per bit, so a pin that idles high shows no false edge after reset
module spc_sync3 #(
    parameter int W = 4,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // ----------------------------------------
    // Filter: a bit moves only once stages two and three agree
    // ----------------------------------------
    always_comb
    begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++)
        begin
            if (s2_r[i] == s3_r[i])
                q_nxt[i] = s3_r[i];
        end
    end

    // Stage one is read by stage two only, to keep metastability contained
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
            q_r <= RST;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule // spc_sync3

// ===== spc_port_ctrl.sv
// Serial peripheral port controller: registers, baud generator, shift engine
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_port_ctrl (
    input wire logic clock,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire spc_pkg::spc_pin_in_t pin_in,
    output spc_pkg::spc_pin_out_t pin_out,
    output logic irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    spc_pkg::spc_pin_in_t pin_s;
    spc_pkg::spc_state_t st_r;
    spc_pkg::spc_state_t st_nxt;
    logic [6:0] ctl_r;
    logic [6:0] ctl_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [15:0] tx_buf_r;
    logic [15:0] tx_buf_nxt;
    logic [15:0] rx_buf_r;
    logic [15:0] rx_buf_nxt;
    logic rx_full_r;
    logic rx_full_nxt;
    logic [3:0] evt_r;
    logic [3:0] evt_nxt;
    logic [3:0] mask_r;
    logic [3:0] mask_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic ssel_d_r;
    logic sclk_d_r;
    logic [7:0] div_cnt_r;
    logic [7:0] div_cnt_nxt;
    logic [5:0] edge_r;
    logic [5:0] edge_nxt;
    logic [15:0] tx_sh_r;
    logic [15:0] tx_sh_nxt;
    logic [15:0] rx_sh_r;
    logic [15:0] rx_sh_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic en;
    logic master;
    logic busy;
    logic ssel_act;
    logic ssel_fall;
    logic wr_data;
    logic rd_data;
    logic start_m;
    logic start_s;
    logic tick;
    logic edge_evt;
    logic sample_edge;
    logic in_bit;
    logic done;
    logic [5:0] last_edge;
    logic [15:0] rx_word;
    logic [15:0] tx_load;
    logic [3:0] hw_set;

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    spc_sync3 #(
        .W(4),
        .RST(`SPC_SYNC_RST)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .d(pin_in),
        .q(pin_s)
    );

    // ----------------------------------------
    // Shared decode terms
    // ----------------------------------------
    assign en = ctl_r[`SPC_CN_EN];
    assign master = ctl_r[`SPC_CN_MS];
    assign busy = (st_r == spc_pkg::SPC_RUN);
    assign ssel_act = !pin_s.ssel_n;
    assign ssel_fall = ssel_d_r && !pin_s.ssel_n;
    assign wr_data = reg_wr && (reg_addr == `SPC_OFF_DATA);
    assign rd_data = reg_rd && (reg_addr == `SPC_OFF_DATA);
    // Master starts on an accepted data write while enabled
    assign start_m = wr_data && !busy && en && master;
    // Slave starts when its select goes active
    assign start_s = !busy && en && !master && ssel_fall;
    // Twice the character length edges, counted from zero
    assign last_edge = (cfg_r[`SPC_CF_CHR] ? `SPC_CHAR_LONG : `SPC_CHAR_SHORT) * 6'h02 - 6'h01;
    // Half-period tick; only counts in master mode
    assign tick = master && busy && (div_cnt_r == div_r);
    // Sample on even edges for phase zero, odd for phase one
    assign sample_edge = (edge_r[0] == cfg_r[`SPC_CF_PHA]);
    assign in_bit = master ? pin_s.miso : pin_s.mosi;
    // Eight-bit characters sit in the upper byte so bit 15 leads
    assign tx_load = cfg_r[`SPC_CF_CHR] ? tx_buf_nxt : {tx_buf_nxt[7:0], `SPC_RST_BYTE};

    // Slave edges come from the filtered clock pin
    always_comb
    begin
        edge_evt = tick;
        if (!master)
            edge_evt = busy && (pin_s.sclk != sclk_d_r);
    end

    // ----------------------------------------
    // Shift engine next state
    // ----------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        div_cnt_nxt = div_cnt_r;
        edge_nxt = edge_r;
        tx_sh_nxt = tx_sh_r;
        rx_sh_nxt = rx_sh_r;
        sclk_nxt = sclk_r;
        done = 1'b0;
        rx_word = rx_sh_r;
        unique case (st_r)
            spc_pkg::SPC_IDLE:
            begin
                // Idle clock level equals polarity
                sclk_nxt = cfg_r[`SPC_CF_POL];
                div_cnt_nxt = `SPC_RST_BYTE;
                edge_nxt = `SPC_RST_EDGE;
                if (start_m || start_s)
                begin
                    st_nxt = spc_pkg::SPC_RUN;
                    tx_sh_nxt = start_m ? tx_load : (cfg_r[`SPC_CF_CHR] ? tx_buf_r
                        : {tx_buf_r[7:0], `SPC_RST_BYTE});
                    rx_sh_nxt = `SPC_RST_WORD;
                end
            end
            spc_pkg::SPC_RUN:
            begin
                // Divider counts only while mastering
                if (master)
                    div_cnt_nxt = tick ? `SPC_RST_BYTE : div_cnt_r + 8'h01;
                if (edge_evt)
                begin
                    sclk_nxt = master ? !sclk_r : sclk_r;
                    edge_nxt = edge_r + 6'h01;
                    if (sample_edge)
                        rx_sh_nxt = {rx_sh_r[14:0], in_bit};
                    else if (edge_r != `SPC_RST_EDGE)
                        tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
                    if (edge_r == last_edge)
                    begin
                        st_nxt = spc_pkg::SPC_IDLE;
                        done = 1'b1;
                        rx_word = rx_sh_nxt;
                    end
                end
                // A slave deselected mid-character abandons it silently
                if (!master && !ssel_act)
                    st_nxt = spc_pkg::SPC_IDLE;
                // Disabling stops engine and baud generator at once
                if (!en)
                begin
                    st_nxt = spc_pkg::SPC_IDLE;
                    done = 1'b0;
                end
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r <= spc_pkg::SPC_IDLE;
            div_cnt_r <= `SPC_RST_BYTE;
            edge_r <= `SPC_RST_EDGE;
            tx_sh_r <= `SPC_RST_WORD;
            rx_sh_r <= `SPC_RST_WORD;
            sclk_r <= 1'b0;
            sclk_d_r <= 1'b0;
            ssel_d_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            div_cnt_r <= div_cnt_nxt;
            edge_r <= edge_nxt;
            tx_sh_r <= tx_sh_nxt;
            rx_sh_r <= rx_sh_nxt;
            sclk_r <= sclk_nxt;
            sclk_d_r <= pin_s.sclk;
            ssel_d_r <= pin_s.ssel_n;
        end
    end

    // ----------------------------------------
    // Hardware flag events
    // ----------------------------------------
    always_comb
    begin
        hw_set = `SPC_RST_EVT;
        // Select is only a fault input when mastering with detection on
        hw_set[`SPC_EV_FAULT] = en && master && ctl_r[`SPC_CN_FDE] && ssel_fall;
        hw_set[`SPC_EV_WRITE_COLLISION_FLAG] = wr_data && busy;
        // A read in the same cycle frees the buffer first
        hw_set[`SPC_EV_OVR] = done && rx_full_r && !rd_data;
        hw_set[`SPC_EV_DONE] = done;
    end

    // ----------------------------------------
    // Register file next state
    // ----------------------------------------
    always_comb
    begin
        ctl_nxt = ctl_r;
        cfg_nxt = cfg_r;
        div_nxt = div_r;
        tx_buf_nxt = tx_buf_r;
        rx_buf_nxt = rx_buf_r;
        rx_full_nxt = rx_full_r;
        evt_nxt = evt_r;
        mask_nxt = mask_r;
        rdata_nxt = `SPC_READ_ZERO;
        // Data writes during a transfer are dropped
        if (wr_data && !busy)
            tx_buf_nxt = reg_wdata;
        if (reg_wr && (reg_addr == `SPC_OFF_CTL))
        begin
            ctl_nxt = reg_wdata[6:0];
            // Rising master select is refused while selected
            if (!master && reg_wdata[`SPC_CN_MS] && ssel_act)
                ctl_nxt[`SPC_CN_MS] = 1'b0;
        end
        if (reg_wr && (reg_addr == `SPC_OFF_CFG))
            cfg_nxt = reg_wdata[7:0] & `SPC_CF_MASK;
        if (reg_wr && (reg_addr == `SPC_OFF_DIV))
            div_nxt = reg_wdata[7:0];
        if (reg_wr && (reg_addr == `SPC_OFF_MASK))
            mask_nxt = reg_wdata[3:0];
        if (reg_wr && (reg_addr == `SPC_OFF_EVT))
            evt_nxt = evt_r & ~reg_wdata[3:0];
        // Hardware sets win over any software clear in the same cycle
        ctl_nxt[`SPC_CN_FLAG_MSB:`SPC_CN_FLAG_LSB] = ctl_nxt[`SPC_CN_FLAG_MSB:`SPC_CN_FLAG_LSB] | hw_set;
        evt_nxt = evt_nxt | hw_set;
        // Receive buffer keeps the older character on overrun
        if (rd_data)
            rx_full_nxt = 1'b0;
        if (done && !hw_set[`SPC_EV_OVR])
        begin
            rx_buf_nxt = cfg_r[`SPC_CF_CHR] ? rx_word : {`SPC_RST_BYTE, rx_word[7:0]};
            rx_full_nxt = 1'b1;
        end
        // Read data, answered the cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                `SPC_OFF_DATA: rdata_nxt = rx_buf_r;
                `SPC_OFF_CTL: rdata_nxt = {8'h00, busy, ctl_r};
                `SPC_OFF_CFG: rdata_nxt = {8'h00, cfg_r};
                `SPC_OFF_DIV: rdata_nxt = {8'h00, div_r};
                `SPC_OFF_EVT: rdata_nxt = {12'h000, evt_r};
                `SPC_OFF_MASK: rdata_nxt = {12'h000, mask_r};
                default: rdata_nxt = `SPC_READ_ZERO;
            endcase
        end
    end

    // Register file registers; reset clears all of them except the mask, which resets to all ones
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctl_r <= `SPC_RST_CTL;
            cfg_r <= `SPC_RST_BYTE;
            div_r <= `SPC_RST_BYTE;
            tx_buf_r <= `SPC_RST_WORD;
            rx_buf_r <= `SPC_RST_WORD;
            rx_full_r <= 1'b0;
            evt_r <= `SPC_RST_EVT;
            mask_r <= `SPC_RST_MASK;
            rdata_r <= `SPC_READ_ZERO;
        end
        else
        begin
            ctl_r <= ctl_nxt;
            cfg_r <= cfg_nxt;
            div_r <= div_nxt;
            tx_buf_r <= tx_buf_nxt;
            rx_buf_r <= rx_buf_nxt;
            rx_full_r <= rx_full_nxt;
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata = rdata_r;
    // Software-set flags also interrupt, since the flag itself is the source
    assign irq = cfg_r[`SPC_CF_IE]
        && |((ctl_r[`SPC_CN_FLAG_MSB:`SPC_CN_FLAG_LSB] | evt_r) & mask_r);

    // Pins: master owns clock and data out, slave drives only while selected
    always_comb
    begin
        pin_out.sclk_out = sclk_r;
        pin_out.sclk_oe = en && master;
        pin_out.mosi_out = tx_sh_r[15];
        pin_out.mosi_oe = en && master;
        pin_out.miso_out = tx_sh_r[15];
        pin_out.miso_oe = en && !master && ssel_act;
    end

endmodule // spc_port_ctrl

// ===== spc_link_model.sv
// Behavioural serial slave standing on the far side of the controller
`timescale 1ns/100ps

module spc_link_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic pol,
    input wire logic pha,
    input wire logic active,
    input wire logic [15:0] tx_word,
    output logic miso,
    output logic [15:0] rx_word
);
    logic sclk_q;
    logic act_q;
    logic moved;
    logic samp;
    logic [15:0] sr;

    // Sample edge is the active edge unless phase is set
    assign moved = sclk != sclk_q;
    assign samp = moved && ((sclk == ~pol) != pha);

    // ------
    // Shifter
    // ------
    // Released line toggles so a stale bit never passes for data
    always @(posedge clock)
    begin
        sclk_q <= sclk;
        act_q <= active;
        if (reset)
        begin
            miso <= 1'b0;
            rx_word <= 16'h0000;
        end
        else if (!active)
            miso <= ~miso;
        else if (!act_q)
        begin
            sr <= tx_word;
            rx_word <= 16'h0000;
            miso <= pha ? miso : tx_word[15];
        end
        else if (samp)
            rx_word <= {rx_word[14:0], mosi};
        else if (moved)
        begin
            miso <= pha ? sr[15] : sr[14];
            sr <= sr << 1;
        end
    end
endmodule // spc_link_model

// ===== spc_port_ctrl_assertions.sv
// Port checks for the serial port controller
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_port_ctrl_assertions (
    input wire logic clock,
    input wire logic reset,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire spc_pkg::spc_pin_in_t pin_in,
    input wire spc_pkg::spc_pin_out_t pin_out,
    input wire logic irq
);
    logic [7:0] cfg_r, cfg_nxt, div_r, div_nxt, cnt_r, cnt_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic run_r, run_nxt, sclk_r, tog;

    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);

    // Shadow registers and the gap since the last serial clock change
    always_comb
    begin
        cfg_nxt = cfg_r;
        div_nxt = div_r;
        mask_nxt = mask_r;
        if (reg_wr && reg_addr == `SPC_OFF_CFG)
            cfg_nxt = reg_wdata[7:0] & `SPC_CF_MASK;
        if (reg_wr && reg_addr == `SPC_OFF_DIV)
            div_nxt = reg_wdata[7:0];
        if (reg_wr && reg_addr == `SPC_OFF_MASK)
            mask_nxt = reg_wdata[3:0];
        tog = pin_out.sclk_out != sclk_r;
        cnt_nxt = tog ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
        run_nxt = tog || (run_r && cnt_r < div_r);
    end

    // Register stage of the shadows
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cfg_r <= 8'h00;
            div_r <= 8'h00;
            mask_r <= `SPC_RST_MASK;
            cnt_r <= 8'h00;
            run_r <= 1'b0;
            sclk_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            div_r <= div_nxt;
            mask_r <= mask_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            sclk_r <= pin_out.sclk_out;
        end
    end

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == `SPC_READ_ZERO)
        else $error("read data outside a read answer");
    unmapped_zero_a: assert property (reg_rd && reg_addr > `SPC_OFF_MASK |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    reset_clear_a: assert property (disable iff (1'b0) $fell(reset) |-> !irq && pin_out == '0)
        else $error("outputs not clear after reset");
    half_period_a: assert property (tog && run_r |-> cnt_r == div_r)
        else $error("serial clock half period wrong");
    div_read_a: assert property (reg_rd && reg_addr == `SPC_OFF_DIV |=> reg_rdata == {8'h00, div_r})
        else $error("divider read back wrong");
    cfg_read_a: assert property (reg_rd && reg_addr == `SPC_OFF_CFG |=> reg_rdata == {8'h00, cfg_r})
        else $error("format read back wrong");
    irq_gate_a: assert property (irq |-> cfg_r[`SPC_CF_IE] && mask_r != 4'h0)
        else $error("interrupt while disabled");
    one_driver_a: assert property (pin_out.miso_oe |-> !pin_out.sclk_oe && $stable(pin_out.sclk_out))
        else $error("clock generated while a selected slave");
    master_pins_a: assert property (pin_out.sclk_oe == pin_out.mosi_oe)
        else $error("master pins driven apart");

    cover property (tog && run_r);
    cover property ($rose(irq));
    cover property (pin_out.miso_oe);
endmodule // spc_port_ctrl_assertions

// ===== spc_port_ctrl_bench.sv
// Self-checking bench for the serial port controller
`timescale 1ns/100ps
`include "spc_map.svh"

module spc_port_ctrl_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic irq;
    logic ssel_n = 1'b1;
    logic ext_sclk = 1'b0;
    logic ext_mosi = 1'b0;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic active = 1'b0;
    logic [15:0] mtx = 16'h0000;
    logic miso_m;
    logic [15:0] mrx;
    int fails = 0;
    int comparisons = 0;
    spc_pkg::spc_pin_in_t pin_in;
    spc_pkg::spc_pin_out_t pin_out;

    // Wire levels; an undriven clock stands still at its idle level
    assign pin_in.sclk = pin_out.sclk_oe ? pin_out.sclk_out : ext_sclk;
    assign pin_in.mosi = pin_out.mosi_oe ? pin_out.mosi_out : (ssel_n ? ~pin_out.mosi_out : ext_mosi);
    assign pin_in.miso = pin_out.miso_oe ? pin_out.miso_out : miso_m;
    assign pin_in.ssel_n = ssel_n;

    always #4 clock = ~clock;

    spc_port_ctrl dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .irq(irq));
    spc_link_model peer (.clock(clock), .reset(reset), .sclk(pin_in.sclk), .mosi(pin_in.mosi), .pol(pol),
        .pha(pha), .active(active), .tx_word(mtx), .miso(miso_m), .rx_word(mrx));

    // ------
    // Bus tasks
    // ------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    // Answer is looked at mid-cycle, once the launching edge has settled
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk(reg_rdata, e);
        @(posedge clock);
    endtask

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    task automatic chk_irq(input logic e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clock);
        chk({15'h0000, irq}, {15'h0000, e});
        @(posedge clock);
    endtask

    // One master transfer with a colliding write, ended by the done interrupt
    task automatic xfer(input logic [7:0] cf, input logic [15:0] sw, input logic [15:0] lw,
        input logic rdd, input logic [15:0] ex, input logic [15:0] ec);
        logic [15:0] m;
        int n;
        m = cf[2] ? 16'hFFFF : 16'h00FF;
        n = 0;
        wr(`SPC_OFF_CFG, {8'h00, cf});
        pol <= cf[0];
        pha <= cf[1];
        mtx <= cf[2] ? lw : {lw[7:0], 8'h00};
        wr(`SPC_OFF_DATA, sw);
        // Peer wakes once the idle clock has moved to the new polarity
        active <= 1'b1;
        wr(`SPC_OFF_DATA, ~sw);
        rd(`SPC_OFF_CTL, 16'h0093);
        idle(1);
        while (irq !== 1'b1 && n < 600)
        begin
            @(negedge clock);
            n++;
        end
        chk_irq(1'b1);
        if (rdd)
            rd(`SPC_OFF_DATA, ex);
        chk(mrx & m, sw & m);
        rd(`SPC_OFF_CTL, ec);
        wr(`SPC_OFF_CTL, 16'h0003);
        wr(`SPC_OFF_EVT, 16'h000F);
        active <= 1'b0;
        chk_irq(1'b0);
    endtask

    // Bench acts as master toward a slave-mode controller: polarity 0, phase 0, 8 bits
    task automatic slave(input logic [7:0] sw, input logic [7:0] mw);
        logic [7:0] got;
        got = 8'h00;
        ssel_n <= 1'b0;
        idle(8);
        chk({15'h0000, pin_out.miso_oe}, 16'h0001);
        for (int b = 7; b >= 0; b--)
        begin
            ext_mosi <= mw[b];
            idle(8);
            ext_sclk <= 1'b1;
            got[b] = pin_in.miso;
            idle(8);
            ext_sclk <= 1'b0;
        end
        idle(8);
        rd(`SPC_OFF_DATA, {8'h00, mw});
        chk({8'h00, got}, {8'h00, sw});
        rd(`SPC_OFF_CTL, 16'h0041);
        ssel_n <= 1'b1;
    endtask

    task automatic test_done();
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------
    // Sequence
    // ------
    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        for (int a = 0; a < 7; a++)
            rd(a[2:0], a == 5 ? 16'h000F : 16'h0000);
        wr(`SPC_OFF_CFG, 16'hFFFF);
        rd(`SPC_OFF_CFG, 16'h0087);
        wr(`SPC_OFF_DIV, 16'h0005);
        rd(`SPC_OFF_DIV, 16'h0005);
        wr(`SPC_OFF_MASK, 16'h0008);
        wr(`SPC_OFF_CTL, 16'h0003);
        for (int i = 0; i < 4; i++)
            xfer(8'h80 | i[7:0], 16'h3CA5 + i[15:0], 16'h005A + i[15:0], 1'b1, 16'h005A + i[15:0], 16'h0053);
        xfer(8'h84, 16'h9C31, 16'h4E6B, 1'b0, 16'h0000, 16'h0053);
        xfer(8'h87, 16'h2D5A, 16'hB1E4, 1'b1, 16'h4E6B, 16'h0073);
        wr(`SPC_OFF_MASK, 16'h000F);
        wr(`SPC_OFF_CTL, 16'h000B);
        chk_irq(1'b1);
        wr(`SPC_OFF_CFG, 16'h0000);
        chk_irq(1'b0);
        wr(`SPC_OFF_CFG, 16'h0080);
        wr(`SPC_OFF_CTL, 16'h0003);
        ssel_n <= 1'b0;
        idle(8);
        rd(`SPC_OFF_CTL, 16'h0003);
        ssel_n <= 1'b1;
        wr(`SPC_OFF_CTL, 16'h0007);
        idle(8);
        ssel_n <= 1'b0;
        idle(8);
        rd(`SPC_OFF_CTL, 16'h000F);
        chk_irq(1'b1);
        wr(`SPC_OFF_CTL, 16'h0000);
        wr(`SPC_OFF_CTL, 16'h0003);
        rd(`SPC_OFF_CTL, 16'h0001);
        ssel_n <= 1'b1;
        wr(`SPC_OFF_EVT, 16'h000F);
        idle(8);
        wr(`SPC_OFF_CTL, 16'h0002);
        wr(`SPC_OFF_DATA, 16'h00C6);
        rd(`SPC_OFF_CTL, 16'h0002);
        wr(`SPC_OFF_CTL, 16'h0001);
        wr(`SPC_OFF_DATA, 16'h00B4);
        slave(8'hB4, 8'h6D);
        reset <= 1'b1;
        idle(2);
        reset <= 1'b0;
        for (int a = 0; a < 4; a++)
            rd(a[2:0], 16'h0000);
        test_done();
    end

    // Watchdog well beyond the fewer than two thousand cycles the sequence needs
    initial
    begin
        repeat (8000) @(posedge clock);
        fails++;
        test_done();
    end
endmodule // spc_port_ctrl_bench

bind spc_port_ctrl spc_port_ctrl_assertions chk_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .irq(irq));
